// ---- core/ecl_loader.v ----
`timescale 1ns/1ns
`include "ecl_regs.vh"
module ecl_loader (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        nrst_i,
  // Control
  input  wire [3:0]  cond_id_i,
  input  wire        start_dl_i,
  input  wire        start_ul_i,
  // Byte stream from the EEPROM reader (download) or sequencer (upload)
  input  wire        byte_vld_i,
  input  wire [7:0]  byte_i,
  output reg         byte_rdy_o,
  // Register-transfer side
  output reg         rt_vld_o,
  output reg  [15:0] rt_addr_o,
  output reg  [7:0]  rt_data_o,
  output reg         rt_exec_o,
  // EEPROM write side (upload)
  output reg         ee_wr_o,
  output reg  [7:0]  ee_wdata_o,
  output reg  [15:0] ee_ptr_o,
  // Status
  output reg         busy_o,
  output reg         paused_o,
  output reg         chk_err_o,
  output reg         done_o,
  output reg         arb_lost_o,
  // I2C pins and bus arbitration
  input  wire        scl_i,
  input  wire        sda_i,
  input  wire        sda_drv_hi_i,
  input  wire        xfer_req_i,
  input  wire        xfer_done_i,
  output reg         bus_grant_o,
  output reg         bus_busy_o
);
  reg  [2:0]  st_reg;
  reg         upl_reg;
  reg         skip_reg;
  reg  [6:0]  cnt_reg;
  reg  [7:0]  sum_reg;
  reg  [3:0]  id_reg;
  reg         scl_m_reg;
  reg         scl_s_reg;
  reg         sda_m_reg;
  reg         sda_s_reg;
  reg         map_clr;
  reg         map_add;
  wire        map_empty;
  wire        map_hit;
  wire        arb_grant;
  wire        arb_lost;
  wire        arb_busy;

  wire        take   = byte_vld_i && byte_rdy_o;
  wire        is_cnd = (byte_i[7:4] == `ECL_OP_COND_HI);
  wire [7:0]  cdiff  = byte_i - `ECL_OP_COND_BASE;
  wire [3:0]  cval   = cdiff[3:0];
  // Run unless an id is set, the map is nonempty and holds no match
  wire        run    = (id_reg == 4'h0) || map_empty || map_hit;

  ecl_cond_map u_map (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .clear_i   (map_clr),
    .add_i     (map_add),
    .value_i   (cval),
    .id_i      (id_reg),
    .empty_o   (map_empty),
    .hit_o     (map_hit)
  );

  // Pin levels pass two flops before the arbiter sees them
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
    end else begin
      scl_m_reg <= scl_i;
      scl_s_reg <= scl_m_reg;
      sda_m_reg <= sda_i;
      sda_s_reg <= sda_m_reg;
    end
  end

  // Shared EEPROM on a dedicated or multi-master bus
  ecl_bus_arb u_arb (
    .clk_sys_i    (clk_sys_i),
    .nrst_i       (nrst_i),
    .scl_s_i      (scl_s_reg),
    .sda_s_i      (sda_s_reg),
    .sda_drv_hi_i (sda_drv_hi_i),
    .own_active_i (bus_grant_o),
    .req_i        (xfer_req_i),
    .done_i       (xfer_done_i),
    .grant_o      (arb_grant),
    .lost_o       (arb_lost),
    .busy_o       (arb_busy)
  );

  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      bus_grant_o <= 1'b0;
      bus_busy_o  <= 1'b0;
      arb_lost_o  <= 1'b0;
    end else begin
      bus_grant_o <= arb_grant;
      bus_busy_o  <= arb_busy;
      arb_lost_o  <= arb_lost;
    end
  end

  // Map updates only on conditional codes during download
  always @* begin
    map_clr = 1'b0;
    map_add = 1'b0;
    if (take && st_reg == `ECL_ST_OP && !upl_reg && is_cnd) begin
      map_clr = (cval == 4'h0);
      map_add = (cval != 4'h0);
    end
  end

  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      st_reg     <= `ECL_ST_IDLE;
      upl_reg    <= 1'b0;
      skip_reg   <= 1'b0;
      cnt_reg    <= 7'h00;
      sum_reg    <= 8'h00;
      id_reg     <= `ECL_ID_RST;
      byte_rdy_o <= 1'b0;
      rt_vld_o   <= 1'b0;
      rt_addr_o  <= 16'h0000;
      rt_data_o  <= 8'h00;
      rt_exec_o  <= 1'b0;
      ee_wr_o    <= 1'b0;
      ee_wdata_o <= 8'h00;
      ee_ptr_o   <= 16'h0000;
      busy_o     <= 1'b0;
      paused_o   <= 1'b0;
      chk_err_o  <= 1'b0;
      done_o     <= 1'b0;
    end else begin
      rt_vld_o <= 1'b0;
      ee_wr_o  <= 1'b0;
      done_o   <= 1'b0;
      if (ee_wr_o) begin
        ee_ptr_o <= ee_ptr_o + 16'h0001;
      end
      case (st_reg)
        `ECL_ST_IDLE: begin
          byte_rdy_o <= 1'b0;
          if (start_dl_i || start_ul_i) begin
            // Id captured at start; software sets it beforehand
            id_reg     <= cond_id_i;
            upl_reg    <= start_ul_i && !start_dl_i;
            skip_reg   <= 1'b0;
            busy_o     <= 1'b1;
            byte_rdy_o <= 1'b1;
            st_reg     <= `ECL_ST_OP;
            if (!paused_o) begin
              sum_reg <= 8'h00;
            end
            paused_o   <= 1'b0;
            chk_err_o  <= 1'b0;
          end
        end
        `ECL_ST_OP: begin
          if (take) begin
            // Pause is never stored, so it stays out of the upload checksum
            if (!(upl_reg && byte_i == `ECL_OP_PAUSE)) begin
              sum_reg <= sum_reg + byte_i;
            end
            if (upl_reg) begin
              ee_wr_o    <= (byte_i != `ECL_OP_PAUSE);
              ee_wdata_o <= byte_i;
            end
            if (byte_i <= `ECL_OP_RT_MAX) begin
              cnt_reg   <= byte_i[6:0];
              rt_exec_o <= upl_reg || (run && !skip_reg);
              st_reg    <= `ECL_ST_ADDR_LO;
            end else if (is_cnd && !upl_reg) begin
              // Zero or matching value ends a skip
              if (cval == 4'h0 || cval == id_reg) begin
                skip_reg <= 1'b0;
              end else if (id_reg != 4'h0 && !map_hit) begin
                skip_reg <= 1'b1;
              end
            end else if (byte_i == `ECL_OP_PAUSE && upl_reg) begin
              // Pointer kept for a resumed upload
              paused_o   <= 1'b1;
              busy_o     <= 1'b0;
              byte_rdy_o <= 1'b0;
              st_reg     <= `ECL_ST_IDLE;
            end else if (byte_i == `ECL_OP_EOD) begin
              byte_rdy_o <= !upl_reg;
              st_reg     <= upl_reg ? `ECL_ST_EOD_UP : `ECL_ST_CHK;
            end
          end
        end
        `ECL_ST_ADDR_LO: begin
          if (take) begin
            sum_reg         <= sum_reg + byte_i;
            rt_addr_o[7:0]  <= byte_i;
            ee_wr_o         <= upl_reg;
            ee_wdata_o      <= byte_i;
            st_reg          <= `ECL_ST_ADDR_HI;
          end
        end
        `ECL_ST_ADDR_HI: begin
          if (take) begin
            sum_reg         <= sum_reg + byte_i;
            rt_addr_o[15:8] <= byte_i;
            ee_wr_o         <= upl_reg;
            ee_wdata_o      <= byte_i;
            st_reg          <= `ECL_ST_DATA;
          end
        end
        `ECL_ST_DATA: begin
          if (take) begin
            sum_reg    <= sum_reg + byte_i;
            rt_vld_o   <= rt_exec_o;
            rt_data_o  <= byte_i;
            ee_wr_o    <= upl_reg;
            ee_wdata_o <= byte_i;
            cnt_reg    <= cnt_reg - 7'h01;
            if (cnt_reg == 7'h00) begin
              st_reg <= `ECL_ST_OP;
            end
          end
          if (rt_vld_o) begin
            rt_addr_o <= rt_addr_o + 16'h0001;
          end
        end
        `ECL_ST_EOD_UP: begin
          // Checksum follows the end code, then pointer back to zero
          if (!ee_wr_o) begin
            ee_wr_o    <= 1'b1;
            ee_wdata_o <= ~sum_reg + 8'h01;
            st_reg     <= `ECL_ST_CHK;
          end
        end
        `ECL_ST_CHK: begin
          if (upl_reg) begin
            if (ee_wr_o) begin
              st_reg <= `ECL_ST_IDLE;
              busy_o <= 1'b0;
              done_o <= 1'b1;
            end
          end else if (take) begin
            // Stored byte makes the running sum zero when intact
            chk_err_o  <= ((sum_reg + byte_i) != 8'h00);
            byte_rdy_o <= 1'b0;
            busy_o     <= 1'b0;
            done_o     <= 1'b1;
            st_reg     <= `ECL_ST_IDLE;
          end
        end
        default: begin
          st_reg <= `ECL_ST_IDLE;
        end
      endcase
      if (st_reg == `ECL_ST_CHK && (upl_reg ? ee_wr_o : take)) begin
        ee_ptr_o <= 16'h0000;
      end
    end
  end
endmodule // ecl_loader

// ---- core/ecl_regs.vh ----
`ifndef ECL_REGS_VH
`define ECL_REGS_VH
// Instruction codes
`define ECL_OP_RT_MAX      8'h7f
`define ECL_OP_COND_BASE   8'hb0
`define ECL_OP_COND_HI     4'hb
`define ECL_OP_PAUSE       8'hfe
`define ECL_OP_EOD         8'hff
// Condition map and condition id reset values
`define ECL_MAP_RST        16'h0000
`define ECL_ID_RST         4'h0
// Arbitration timeout, in SCL cycles
`define ECL_ARB_SCL_CYC    8'd255
// Parser states
`define ECL_ST_IDLE        3'd0
`define ECL_ST_OP          3'd1
`define ECL_ST_ADDR_LO     3'd2
`define ECL_ST_ADDR_HI     3'd3
`define ECL_ST_DATA        3'd4
`define ECL_ST_EOD_UP      3'd5
`define ECL_ST_CHK         3'd6
// Arbiter states
`define ECL_AR_IDLE        2'd0
`define ECL_AR_WAIT        2'd1
`define ECL_AR_OWN         2'd2
`endif

// ---- core/ecl_cond_map.v ----
`timescale 1ns/1ns
`include "ecl_regs.vh"
module ecl_cond_map (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        nrst_i,
  // Map update
  input  wire        clear_i,
  input  wire        add_i,
  input  wire [3:0]  value_i,
  input  wire [3:0]  id_i,
  // Lookup
  output wire        empty_o,
  output wire        hit_o
);
  reg  [15:0] map_reg;
  wire [15:0] map_next;

  // One flop per condition value so several can stand at once
  genvar g;
  generate
    for (g = 1; g < 16; g = g + 1) begin : g_map
      assign map_next[g] = clear_i ? 1'b0 : (map_reg[g] | (add_i && value_i == g));
    end
  endgenerate
  assign map_next[0] = 1'b0;

  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      map_reg <= `ECL_MAP_RST;
    end else begin
      map_reg <= map_next;
    end
  end

  assign empty_o = (map_reg == `ECL_MAP_RST);
  assign hit_o   = map_reg[id_i];
endmodule // ecl_cond_map

// ---- core/ecl_bus_arb.v ----
`timescale 1ns/1ns
`include "ecl_regs.vh"
module ecl_bus_arb (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        nrst_i,
  // Synchronised bus levels
  input  wire        scl_s_i,
  input  wire        sda_s_i,
  input  wire        sda_drv_hi_i,
  input  wire        own_active_i,
  // Request side
  input  wire        req_i,
  input  wire        done_i,
  output reg         grant_o,
  output reg         lost_o,
  output reg         busy_o
);
  reg [1:0] st_reg;
  reg       scl_d_reg;
  reg       sda_d_reg;
  reg [7:0] tmr_reg;

  wire start_ev = scl_s_i && scl_d_reg && sda_d_reg && !sda_s_i;
  wire stop_ev  = scl_s_i && scl_d_reg && !sda_d_reg && sda_s_i;
  wire scl_rise = scl_s_i && !scl_d_reg;
  wire tmo      = (tmr_reg == `ECL_ARB_SCL_CYC);

  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      st_reg    <= `ECL_AR_IDLE;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      tmr_reg   <= 8'h00;
      grant_o   <= 1'b0;
      lost_o    <= 1'b0;
      busy_o    <= 1'b0;
    end else begin
      scl_d_reg <= scl_s_i;
      sda_d_reg <= sda_s_i;
      lost_o    <= 1'b0;
      // Bus busy tracked from start and stop seen on the lines
      if (start_ev && !own_active_i) begin
        busy_o <= 1'b1;
      end else if (stop_ev) begin
        busy_o <= 1'b0;
      end
      case (st_reg)
        `ECL_AR_IDLE: begin
          if (req_i) begin
            // SCL low or bus busy before start: postpone
            if (busy_o || !scl_s_i || start_ev) begin
              st_reg  <= `ECL_AR_WAIT;
              tmr_reg <= 8'h00;
            end else begin
              st_reg  <= `ECL_AR_OWN;
              grant_o <= 1'b1;
            end
          end
        end
        `ECL_AR_WAIT: begin
          if (!req_i) begin
            // Request withdrawn: never grant a bus nobody asked
            st_reg  <= `ECL_AR_IDLE;
            tmr_reg <= 8'h00;
          end else if (stop_ev || tmo) begin
            // Retry on stop, or force after timeout
            tmr_reg <= 8'h00;
            if (scl_s_i && (stop_ev || !busy_o || tmo)) begin
              st_reg  <= `ECL_AR_OWN;
              grant_o <= 1'b1;
              busy_o  <= 1'b0;
            end
          end else if (!busy_o && scl_s_i && scl_d_reg && sda_s_i) begin
            // Postponed only for a low clock; bus idle again
            st_reg  <= `ECL_AR_OWN;
            grant_o <= 1'b1;
          end else if (scl_rise) begin
            tmr_reg <= tmr_reg + 8'h01;
          end
        end
        `ECL_AR_OWN: begin
          if (sda_drv_hi_i && !sda_s_i && scl_s_i) begin
            // Another master holds SDA low: drop at once
            grant_o <= 1'b0;
            lost_o  <= 1'b1;
            st_reg  <= `ECL_AR_WAIT;
            tmr_reg <= 8'h00;
          end else if (done_i) begin
            grant_o <= 1'b0;
            st_reg  <= `ECL_AR_IDLE;
          end
        end
        default: begin
          st_reg  <= `ECL_AR_IDLE;
          grant_o <= 1'b0;
        end
      endcase
    end
  end
endmodule // ecl_bus_arb

// ---- bench/ecl_loader_checker.sv ----
`timescale 1ns/1ns
module ecl_loader_checker (
  // Clock, reset, inputs
  input wire        clk_sys_i,
  input wire        nrst_i,
  input wire        start_dl_i,
  input wire        start_ul_i,
  input wire        xfer_req_i,
  input wire        scl_i,
  input wire        sda_i,
  // Watched outputs
  input wire        busy_o,
  input wire        byte_rdy_o,
  input wire        rt_vld_o,
  input wire        rt_exec_o,
  input wire        done_o,
  input wire        paused_o,
  input wire        ee_wr_o,
  input wire [15:0] ee_ptr_o,
  input wire        arb_lost_o,
  input wire        bus_grant_o,
  input wire        bus_busy_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // Six cycles covers the pin synchroniser plus detection
  sequence s_scl_low;
    (!scl_i && xfer_req_i && !bus_grant_o) [*6];
  endsequence
  sequence s_start_seen;
    $fell(sda_i) && scl_i && $past(scl_i) && !bus_grant_o;
  endsequence
  property p_exec; rt_vld_o |-> rt_exec_o; endproperty
  a_exec: assert property (p_exec) else $error("payload write while skipping");
  property p_rdy; start_dl_i && !busy_o |=> byte_rdy_o; endproperty
  a_rdy: assert property (p_rdy) else $error("no byte ready after start");
  property p_done; done_o |=> !done_o && ee_ptr_o == 16'h0000 && !byte_rdy_o; endproperty
  a_done: assert property (p_done) else $error("end of data not idle");
  property p_wr;
    ee_wr_o |=> ee_ptr_o == $past(ee_ptr_o) + 16'h0001 || ee_ptr_o == 16'h0000;
  endproperty
  a_wr: assert property (p_wr) else $error("pointer not advanced");
  property p_pause; $rose(paused_o) && !start_ul_i |=> !byte_rdy_o; endproperty
  a_pause: assert property (p_pause) else $error("pause not idle");
  property p_lost; arb_lost_o |-> ##[0:2] !bus_grant_o; endproperty
  a_lost: assert property (p_lost) else $error("bus kept after loss");
  property p_grant; $rose(bus_grant_o) |-> xfer_req_i; endproperty
  a_grant: assert property (p_grant) else $error("grant without request");
  property p_scl; s_scl_low |=> !bus_grant_o; endproperty
  a_scl: assert property (p_scl) else $error("grant while clock low");
  property p_busy; s_start_seen |-> ##[1:5] bus_busy_o; endproperty
  a_busy: assert property (p_busy) else $error("start not tracked");
endmodule // ecl_loader_checker

// ---- bench/ecl_bus_peer.sv ----
`timescale 1ns/1ns
module ecl_bus_peer (
  // Clock and control
  input wire       clk_sys_i,
  input wire       go_i,
  input wire [9:0] n_i,
  input wire       stop_i,
  // Open-drain levels, high when released
  output reg       scl_o,
  output reg       sda_o
);
  integer k;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Data stays low so no stray start or stop appears mid-transfer
  always begin
    @(posedge clk_sys_i iff go_i);
    #10 sda_o = 1'b0;
    for (k = 0; k < n_i; k++) begin
      repeat (2) @(posedge clk_sys_i);
      #10 scl_o = 1'b0;
      repeat (2) @(posedge clk_sys_i);
      #10 scl_o = 1'b1;
    end
    repeat (2) @(posedge clk_sys_i);
    #10 if (stop_i) sda_o = 1'b1;
  end
endmodule // ecl_bus_peer

// ---- bench/tb.sv ----
`timescale 1ns/1ns
`include "ecl_regs.vh"
module tb;
  reg         clk_sys_i = 1'b0, nrst_i = 1'b0, start_dl_i = 1'b0, start_ul_i = 1'b0;
  reg         byte_vld_i = 1'b0, sda_drv_hi_i = 1'b0, xfer_req_i = 1'b0, xfer_done_i = 1'b0;
  reg         pull = 1'b0, hold = 1'b0, go = 1'b0, stp = 1'b1;
  reg  [3:0]  cond_id_i = 4'h0;
  reg  [7:0]  byte_i = 8'h00, d, sum;
  reg  [9:0]  n = 10'h000;
  reg  [15:0] map, a;
  reg  [7:0]  s[$], wr_q[$];
  reg  [23:0] exp_q[$], got_q[$];
  wire        byte_rdy_o, rt_vld_o, rt_exec_o, ee_wr_o, busy_o, paused_o, chk_err_o;
  wire        done_o, arb_lost_o, bus_grant_o, bus_busy_o, p_scl, p_sda;
  wire [15:0] rt_addr_o, ee_ptr_o;
  wire [7:0]  rt_data_o, ee_wdata_o;
  wire        scl_i = p_scl & ~hold;
  wire        sda_i = p_sda & ~pull;
  integer     fails = 0, n_compared = 0, seed = 18, t, i, j, q, len;
  integer     ids[6] = '{0, 1, 2, 3, 5, 14};

  ecl_loader dut (.*);
  ecl_bus_peer peer (.clk_sys_i(clk_sys_i), .go_i(go), .n_i(n), .stop_i(stp),
    .scl_o(p_scl), .sda_o(p_sda));

  always #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    if (rt_vld_o === 1'b1) got_q.push_back({rt_addr_o, rt_data_o});
    if (ee_wr_o === 1'b1) wr_q.push_back(ee_wdata_o);
  end

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_compared++;
      if (seen !== exp) begin
        fails++;
        $display("mismatch value exp %h seen %h", exp, seen);
      end
    end
  endtask
  task complete_run;
    begin
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task step;
    begin
      @(posedge clk_sys_i);
      #10;
    end
  endtask
  // Byte is taken at the edge after ready is seen
  task put(input [7:0] b);
    begin
      byte_i = b;
      byte_vld_i = 1'b1;
      t = 0;
      while (byte_rdy_o !== 1'b1 && t < 50) begin
        step;
        t++;
      end
      step;
      if (t >= 50) fails++;
    end
  endtask
  task op(input ul);
    begin
      step;
      if (ul) start_ul_i = 1'b1;
      else start_dl_i = 1'b1;
      step;
      start_ul_i = 1'b0;
      start_dl_i = 1'b0;
    end
  endtask
  task wt(input [1:0] w, input integer lim);
    reg hit;
    begin
      t = 0;
      hit = 1'b0;
      while (hit !== 1'b1 && t < lim) begin
        hit = w == 0 ? bus_grant_o : w == 1 ? done_o : w == 2 ? paused_o : arb_lost_o;
        if (hit !== 1'b1) begin
          step;
          t++;
        end
      end
      if (t >= lim) fails++;
    end
  endtask
  // Skipped transfers keep their bytes in the stream
  task rt;
    begin
      len = $random(seed) & 3;
      a = $random(seed);
      s.push_back(len[7:0]);
      s.push_back(a[7:0]);
      s.push_back(a[15:8]);
      for (j = 0; j <= len; j++) begin
        d = $random(seed);
        s.push_back(d);
        if (cond_id_i == 4'h0 || map == 16'h0000 || map[cond_id_i])
          exp_q.push_back({a + j[15:0], d});
      end
    end
  endtask
  task cnd(input [3:0] v);
    begin
      s.push_back(`ECL_OP_COND_BASE + {4'h0, v});
      map = v != 4'h0 ? map | (16'h0001 << v) : 16'h0000;
    end
  endtask
  task dl(input bad);
    begin
      s = {};
      exp_q = {};
      got_q = {};
      map = 16'h0000;
      rt;
      cnd(4'h1);
      rt;
      cnd(4'h2);
      cnd(4'h3);
      rt;
      for (i = 4; i < 16; i++) cnd(i[3:0]);
      rt;
      s.push_back(`ECL_OP_PAUSE);
      rt;
      cnd(4'h0);
      rt;
      s.push_back(`ECL_OP_EOD);
      sum = 8'h00;
      foreach (s[k]) sum = sum + s[k];
      s.push_back(8'h00 - sum + {7'h00, bad});
      op(1'b0);
      foreach (s[k]) put(s[k]);
      byte_vld_i = 1'b0;
      wt(1, 100);
      chk(chk_err_o, bad);
      chk(ee_ptr_o, 0);
      chk(got_q.size(), exp_q.size());
      foreach (exp_q[k]) chk(got_q[k], exp_q[k]);
    end
  endtask
  task peer_go(input [9:0] cnt, input st);
    begin
      n = cnt;
      stp = st;
      go = 1'b1;
      step;
      go = 1'b0;
    end
  endtask
  task fin;
    begin
      xfer_done_i = 1'b1;
      step;
      xfer_done_i = 1'b0;
      xfer_req_i = 1'b0;
    end
  endtask

  initial begin
    #2000000;
    fails++;
    complete_run;
  end

  initial begin
    repeat (8) @(posedge clk_sys_i);
    #10 nrst_i = 1'b1;
    for (q = 0; q < 6; q++) begin
      cond_id_i = ids[q][3:0];
      dl(ids[q] == 5);
    end
    cond_id_i = 4'h0;
    wr_q = {};
    op(1'b1);
    a = $random(seed);
    put(8'h00);
    put(a[7:0]);
    put(a[15:8]);
    put(a[7:0] ^ 8'h3c);
    put(`ECL_OP_PAUSE);
    byte_vld_i = 1'b0;
    wt(2, 50);
    step;
    step;
    chk(paused_o, 1);
    chk(ee_ptr_o, wr_q.size());
    op(1'b1);
    put(`ECL_OP_COND_BASE + 8'h01);
    put(`ECL_OP_EOD);
    byte_vld_i = 1'b0;
    wt(1, 50);
    sum = 8'h00;
    foreach (wr_q[k]) sum = sum + wr_q[k];
    chk(sum, 0);
    chk(wr_q[wr_q.size() - 2], `ECL_OP_EOD);
    chk(ee_ptr_o, 0);
    peer_go(10'd8, 1'b1);
    repeat (4) step;
    xfer_req_i = 1'b1;
    repeat (6) step;
    chk(bus_busy_o, 1);
    chk(bus_grant_o, 0);
    wt(0, 200);
    chk(p_sda, 1);
    fin;
    peer_go(10'd300, 1'b0);
    repeat (4) step;
    xfer_req_i = 1'b1;
    wt(0, 1400);
    chk(t >= 960 && t <= 1100, 1);
    fin;
    repeat (300) step;
    peer_go(10'd0, 1'b1);
    repeat (10) step;
    xfer_req_i = 1'b1;
    wt(0, 30);
    sda_drv_hi_i = 1'b1;
    pull = 1'b1;
    wt(3, 10);
    chk(arb_lost_o, 1);
    step;
    step;
    chk(bus_grant_o, 0);
    pull = 1'b0;
    sda_drv_hi_i = 1'b0;
    xfer_req_i = 1'b0;
    repeat (8) step;
    hold = 1'b1;
    repeat (3) step;
    xfer_req_i = 1'b1;
    repeat (20) step;
    chk(bus_grant_o, 0);
    hold = 1'b0;
    wt(0, 30);
    chk(bus_grant_o, 1);
    fin;
    complete_run;
  end
endmodule // tb

bind ecl_loader ecl_loader_checker u_chk (.*);
